// File: hdl/flash_pe_pkg.sv
// Constants, types and register map of the flash program/erase controller
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package flash_pe_pkg;

  // Register byte addresses
  localparam logic [7:0] LOCK_OFS   = 8'h00;
  localparam logic [7:0] STAT_OFS   = 8'h04;
  localparam logic [7:0] PAGE_OFS   = 8'h08;
  localparam logic [7:0] SECT_OFS   = 8'h0C;
  localparam logic [7:0] FREQH_OFS  = 8'h10;
  localparam logic [7:0] FREQL_OFS  = 8'h14;
  localparam logic [7:0] ADDR_OFS   = 8'h18;
  localparam logic [7:0] DATA_OFS   = 8'h1C;
  localparam logic [7:0] CMD_OFS    = 8'h20;
  localparam logic [7:0] OPT_OFS    = 8'h24;

  // Unlock keys and command codes
  localparam logic [7:0] KEY_FIRST  = 8'h73;
  localparam logic [7:0] KEY_SECOND = 8'h8C;
  localparam logic [1:0] CMD_PROG   = 2'h1;
  localparam logic [1:0] CMD_PAGE   = 2'h2;
  localparam logic [1:0] CMD_MASS   = 2'h3;

  // Status bit positions and option byte fields
  localparam int ST_UNLOCKED = 0;
  localparam int ST_BUSY     = 1;
  localparam int ST_REFUSED  = 2;
  localparam int OPT_WP_BIT  = 0;

  // Reset values
  localparam logic [7:0]  SECT_RST  = 8'h00;
  localparam logic [15:0] FREQ_RST  = 16'h0000;

  // Time targets in microseconds and the kHz-to-cycles divisor
  localparam int unsigned PROG_TIME_US = 40;
  localparam int unsigned PAGE_TIME_US = 10000;
  localparam int unsigned MASS_TIME_US = 200000;
  localparam int unsigned US_PER_MS    = 1000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    LK_LOCKED = 3'h0,
    LK_KEY1   = 3'h1,
    LK_KEY2   = 3'h2,
    LK_PAGE1  = 3'h3,
    LK_OPEN   = 3'h4
  } lock_state_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  data;
    logic        prog;
    logic        page_erase;
    logic        mass_erase;
  } flash_ctrl_t;

endpackage

// File: hdl/flash_program_erase_ctrl.sv
// Flash program/erase sequencer with AXI4-Lite register slave
`timescale 1ns/1ps
module flash_program_erase_ctrl #(
  parameter int ADDR_W = 12,
  parameter int SECT_N = 8
) (
  input  wire logic                      ref_clk,
  input  wire logic                      reset_n,
  input  wire logic [7:0]                s_awaddr,
  input  wire logic                      s_awvalid,
  output logic                           s_awready,
  input  wire logic [31:0]               s_wdata,
  input  wire logic [3:0]                s_wstrb,
  input  wire logic                      s_wvalid,
  output logic                           s_wready,
  output logic [1:0]                     s_bresp,
  output logic                           s_bvalid,
  input  wire logic                      s_bready,
  input  wire logic [7:0]                s_araddr,
  input  wire logic                      s_arvalid,
  output logic                           s_arready,
  output logic [31:0]                    s_rdata,
  output logic [1:0]                     s_rresp,
  output logic                           s_rvalid,
  input  wire logic                      s_rready,
  input  wire logic                      on_chip_debugger_active,
  input  wire logic [7:0]                option_byte_in,
  output flash_pe_pkg::flash_ctrl_t      flash_ctrl_r
);
  import flash_pe_pkg::*;

  localparam int SECT_W = $clog2(SECT_N);

  //--------------------------------------------------------------------
  // Registers
  //--------------------------------------------------------------------
  lock_state_t       lock_r;
  logic [SECT_W-1:0] page_r;
  logic [SECT_N-1:0] sect_r;
  logic [7:0]        freq_hi_r;
  logic [7:0]        freq_lo_r;
  logic [ADDR_W-1:0] addr_r;
  logic [7:0]        data_r;
  logic [7:0]        opt_r;
  logic              opt_loaded_r;
  logic              busy_r;
  logic              refused_r;
  logic [39:0]       op_cnt_r;
  logic [7:0]        aw_addr_r;
  logic              aw_held_r;
  logic [31:0]       w_data_r;
  logic [3:0]        w_strb_r;
  logic              w_held_r;

  logic        dbg;
  logic        wr_go;
  logic        wr_ok;
  logic [7:0]  wr_byte;
  logic        wp_open;
  logic [15:0] flash_clock_khz_value;
  logic [1:0]  cmd;
  logic        cmd_wr;
  logic        allow;
  logic [39:0] target;

  assign dbg     = on_chip_debugger_active;
  assign wr_go   = aw_held_r && w_held_r && !s_bvalid;
  assign wr_byte = w_data_r[7:0];
  assign flash_clock_khz_value = {freq_hi_r, freq_lo_r};
  assign wp_open = opt_r[OPT_WP_BIT];
  assign cmd     = wr_byte[1:0];

  function automatic logic hit(input logic [7:0] ofs);
    hit = wr_go && w_strb_r[0] && (aw_addr_r == ofs);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= OPT_OFS) && (a[1:0] == 2'b00);
  endfunction

  // Cycles = kHz * us / 1000, rounded up, never below one
  function automatic logic [39:0] cycles(input logic [15:0] khz,
                                         input int unsigned us);
    logic [39:0] c;
    c = 40'((40'(khz) * 40'(us) + 40'(US_PER_MS - 1)) / 40'(US_PER_MS));
    cycles = (c == 40'h0) ? 40'h1 : c;
  endfunction

  // Spelled out: a continuous assign would not follow signals read
  // inside a function body, only its arguments
  assign cmd_wr = wr_go && w_strb_r[0] && (aw_addr_r == CMD_OFS) && !busy_r
                  && (cmd != 2'h0);
  assign wr_ok  = 1'b1;

  always_comb begin
    allow  = 1'b0;
    target = cycles(flash_clock_khz_value, PROG_TIME_US);
    if (lock_r == LK_OPEN) begin
      case (cmd)
        CMD_PROG: begin
          allow = dbg || (wp_open && (addr_r[ADDR_W-1 -: SECT_W] == page_r)
                  && !sect_r[addr_r[ADDR_W-1 -: SECT_W]]);
        end
        CMD_PAGE: begin
          allow  = dbg || (wp_open && !sect_r[page_r]);
          target = cycles(flash_clock_khz_value, PAGE_TIME_US);
        end
        CMD_MASS: begin
          allow  = dbg;
          target = cycles(flash_clock_khz_value, MASS_TIME_US);
        end
        default: allow = 1'b0;
      endcase
    end
  end

  //--------------------------------------------------------------------
  // AXI4-Lite write channel
  //--------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_held_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      s_bvalid  <= 1'b0;
      s_bresp   <= RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_wdata;
        w_strb_r <= s_wstrb;
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        s_bvalid  <= 1'b1;
        s_bresp   <= (mapped(aw_addr_r) && wr_ok) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
    end else begin
      s_awready <= !aw_held_r && !(s_awvalid && s_awready) && !wr_go;
      s_wready  <= !w_held_r && !(s_wvalid && s_wready) && !wr_go;
    end
  end

  //--------------------------------------------------------------------
  // AXI4-Lite read channel
  //--------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0000_0000;
      s_rresp   <= RESP_OKAY;
    end else begin
      s_arready <= !s_rvalid && !(s_arvalid && s_arready);
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_rresp  <= mapped(s_araddr) ? RESP_OKAY : RESP_SLVERR;
        if (s_araddr == LOCK_OFS) begin
          s_rdata <= {29'h0, lock_r};
        end else if (s_araddr == STAT_OFS) begin
          s_rdata <= {29'h0, refused_r, busy_r, lock_r == LK_OPEN};
        end else if (s_araddr == PAGE_OFS) begin
          s_rdata <= {{(32-SECT_W){1'b0}}, page_r};
        end else if (s_araddr == SECT_OFS) begin
          s_rdata <= {{(32-SECT_N){1'b0}}, sect_r};
        end else if (s_araddr == FREQH_OFS) begin
          s_rdata <= {24'h0, freq_hi_r};
        end else if (s_araddr == FREQL_OFS) begin
          s_rdata <= {24'h0, freq_lo_r};
        end else if (s_araddr == ADDR_OFS) begin
          s_rdata <= {{(32-ADDR_W){1'b0}}, addr_r};
        end else if (s_araddr == DATA_OFS) begin
          s_rdata <= {24'h0, data_r};
        end else if (s_araddr == OPT_OFS) begin
          s_rdata <= {24'h0, opt_r};
        end else begin
          s_rdata <= 32'h0000_0000;
        end
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  //--------------------------------------------------------------------
  // Lock sequence and page select
  //--------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_r <= LK_LOCKED;
      page_r <= '0;
    end else if (hit(LOCK_OFS)) begin
      // Any other value written here relocks at once
      case (lock_r)
        LK_LOCKED: lock_r <= (wr_byte == KEY_FIRST) ? LK_KEY1 : LK_LOCKED;
        LK_KEY1: begin
          if (wr_byte != KEY_SECOND) begin
            lock_r <= LK_LOCKED;
          end else if (dbg) begin
            lock_r <= LK_OPEN;
          end else begin
            lock_r <= LK_KEY2;
          end
        end
        default: lock_r <= LK_LOCKED;
      endcase
    end else if (hit(PAGE_OFS)) begin
      case (lock_r)
        LK_KEY2: begin
          page_r <= wr_byte[SECT_W-1:0];
          lock_r <= LK_PAGE1;
        end
        LK_PAGE1: begin
          // Second write must repeat the page, else the sequence aborts
          lock_r <= (wr_byte[SECT_W-1:0] == page_r) ? LK_OPEN
                                                    : LK_LOCKED;
        end
        LK_OPEN: begin
          if (dbg && !busy_r) begin
            page_r <= wr_byte[SECT_W-1:0];
          end
        end
        default: begin
          page_r <= wr_byte[SECT_W-1:0];
          lock_r <= LK_LOCKED;
        end
      endcase
    end else if (lock_r == LK_KEY1 || lock_r == LK_KEY2) begin
      lock_r <= lock_r;
    end
  end

  //--------------------------------------------------------------------
  // Protection, frequency and operand registers
  //--------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sect_r    <= SECT_RST;
      freq_hi_r <= FREQ_RST[15:8];
      freq_lo_r <= FREQ_RST[7:0];
      addr_r    <= '0;
      data_r    <= 8'h00;
    end else if (!busy_r) begin
      if (hit(SECT_OFS)) begin
        // Software may only add protection; the debugger may also clear
        sect_r <= dbg ? wr_byte[SECT_N-1:0]
                      : (sect_r | wr_byte[SECT_N-1:0]);
      end
      if (hit(FREQH_OFS)) begin
        freq_hi_r <= wr_byte;
      end
      if (hit(FREQL_OFS)) begin
        freq_lo_r <= wr_byte;
      end
      if (hit(ADDR_OFS)) begin
        addr_r <= w_data_r[ADDR_W-1:0];
      end
      if (hit(DATA_OFS)) begin
        data_r <= wr_byte;
      end
    end
  end

  // Option byte is sampled from the array once after reset release; it
  // lives in flash, so the array keeps it across reset.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      opt_r        <= 8'h00;
      opt_loaded_r <= 1'b0;
    end else if (!opt_loaded_r) begin
      opt_r        <= option_byte_in;
      opt_loaded_r <= 1'b1;
    end
  end

  //--------------------------------------------------------------------
  // Operation sequencer
  //--------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_r       <= 1'b0;
      op_cnt_r     <= 40'h0;
      flash_ctrl_r <= '0;
    end else if (cmd_wr && allow && opt_loaded_r) begin
      busy_r                  <= 1'b1;
      op_cnt_r                <= target;
      flash_ctrl_r.addr       <= addr_r;
      flash_ctrl_r.data       <= data_r;
      flash_ctrl_r.prog       <= (cmd == CMD_PROG);
      flash_ctrl_r.page_erase <= (cmd == CMD_PAGE);
      flash_ctrl_r.mass_erase <= (cmd == CMD_MASS);
    end else if (busy_r) begin
      if (op_cnt_r == 40'h1) begin
        busy_r                  <= 1'b0;
        flash_ctrl_r.prog       <= 1'b0;
        flash_ctrl_r.page_erase <= 1'b0;
        flash_ctrl_r.mass_erase <= 1'b0;
      end
      op_cnt_r <= op_cnt_r - 40'h1;
    end
  end

  // Refused flag: a new refusal wins over a clearing write
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      refused_r <= 1'b0;
    end else if (cmd_wr && !(allow && opt_loaded_r)) begin
      refused_r <= 1'b1;
    end else if (hit(STAT_OFS) && wr_byte[ST_REFUSED]) begin
      refused_r <= 1'b0;
    end
  end

  //--------------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  logic start;
  assign start = cmd_wr && allow && opt_loaded_r;

  sequence s_keys_dbg;
    wr_go && w_strb_r[0] && aw_addr_r == LOCK_OFS && lock_r == LK_KEY1
      && wr_byte == KEY_SECOND && dbg;
  endsequence

  property p_mass_debug_only;
    $rose(flash_ctrl_r.mass_erase) |-> $past(dbg);
  endproperty
  a_mass_debug_only: assert property (p_mass_debug_only)
    else $error("mass erase started without debugger access");

  property p_start_needs_unlock;
    $rose(busy_r) |-> $past(lock_r) == LK_OPEN;
  endproperty
  a_start_needs_unlock: assert property (p_start_needs_unlock)
    else $error("operation started while locked");

  property p_wp_blocks_user;
    start && !dbg |-> wp_open && cmd != CMD_MASS;
  endproperty
  a_wp_blocks_user: assert property (p_wp_blocks_user)
    else $error("user operation passed write protect");

  property p_freq_join;
    wr_go && w_strb_r[0] && aw_addr_r == FREQH_OFS && !busy_r |=>
      flash_clock_khz_value[15:8] == $past(wr_byte);
  endproperty
  a_freq_join: assert property (p_freq_join)
    else $error("frequency high byte not joined");

  property p_pulse_length;
    start ##1 busy_r |-> op_cnt_r == $past(target) && op_cnt_r != 40'h0;
  endproperty
  a_pulse_length: assert property (p_pulse_length)
    else $error("pulse length not scaled from frequency");

  property p_dbg_unlock;
    s_keys_dbg |=> lock_r == LK_OPEN;
  endproperty
  a_dbg_unlock: assert property (p_dbg_unlock)
    else $error("debugger unlock needed page writes");

  property p_user_unlock;
    $rose(lock_r == LK_OPEN) && !$past(dbg) |->
      $past(lock_r) == LK_PAGE1 && $past(lock_r, 2) != LK_LOCKED;
  endproperty
  a_user_unlock: assert property (p_user_unlock)
    else $error("user unlock skipped a step");

  property p_dbg_sect_clear;
    wr_go && w_strb_r[0] && aw_addr_r == SECT_OFS && dbg && !busy_r |=>
      sect_r == $past(wr_byte[SECT_N-1:0]);
  endproperty
  a_dbg_sect_clear: assert property (p_dbg_sect_clear)
    else $error("sector protect not written under debugger");

  property p_option_held;
    opt_loaded_r |=> $stable(opt_r);
  endproperty
  a_option_held: assert property (p_option_held)
    else $error("option byte changed after load");

endmodule

// File: test/flash_array_model.sv
// Behavioural flash array behind the program/erase controller
`timescale 1ns/1ps
module flash_array_model
  import flash_pe_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire flash_pe_pkg::flash_ctrl_t ctrl,
  input  wire logic                 opt_load,
  input  wire logic [7:0]           opt_data,
  input  wire logic [11:0]          peek_addr,
  output logic [7:0]                peek_byte,
  output logic [7:0]                option_byte,
  output logic [19:0]               last_len,
  output logic [1:0]                last_kind,
  output logic [7:0]                pulses
);
  import flash_pe_pkg::*;

  logic [7:0]  mem [0:4095];
  logic [19:0] cnt;
  logic        on;
  logic        was_on;

  assign on        = ctrl.prog | ctrl.page_erase | ctrl.mass_erase;
  assign peek_byte = mem[peek_addr];

  //--------------------------------------------------------------------
  // Storage
  //--------------------------------------------------------------------
  initial begin
    for (int i = 0; i < 4096; i++)
      mem[i] = 8'hFF;
    option_byte = 8'hFF;
    cnt = 20'h0;
    was_on = 1'b0;
    last_len = 20'h0;
    last_kind = 2'h0;
    pulses = 8'h0;
  end

  // Option byte has no reset: it lives in the array, not in logic
  always @(posedge ref_clk) begin
    if (opt_load)
      option_byte <= opt_data | 8'h02;
    was_on <= on;
    cnt <= on ? cnt + 20'h1 : 20'h0;
    if (on && !was_on && ctrl.prog)
      mem[ctrl.addr] <= mem[ctrl.addr] & ctrl.data;
    if (on && !was_on && ctrl.mass_erase)
      for (int i = 0; i < 4096; i++)
        mem[i] <= 8'hFF;
    if (on)
      last_kind <= ctrl.prog ? CMD_PROG : ctrl.page_erase ? CMD_PAGE : CMD_MASS;
    if (!on && was_on) begin
      last_len <= cnt;
      pulses <= pulses + 8'h1;
    end
  end
endmodule

// File: test/flash_program_erase_ctrl_bench.sv
// Self-checking bench of the flash program/erase controller
`timescale 1ns/1ps
module flash_program_erase_ctrl_bench;
  import flash_pe_pkg::*;

  logic ref_clk = 1'b0, reset_n = 1'b0;
  logic [7:0] s_awaddr = 8'h0, s_araddr = 8'h0;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic s_arvalid = 1'b0, s_rready = 1'b0, dbg = 1'b0;
  logic [31:0] s_wdata = 32'h0, s_rdata, rdata_q;
  logic [3:0] s_wstrb = 4'h0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp, last_resp, last_kind;
  logic [7:0] option_byte, opt_data = 8'hFF, peek_byte, pulses;
  logic opt_load = 1'b0;
  logic [11:0] peek_addr = 12'h0;
  logic [19:0] last_len;
  logic [2:0] pg;
  flash_ctrl_t flash_ctrl_r;
  int n_fail = 0, check_count = 0, cycles = 0, khz = 0;

  flash_program_erase_ctrl i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .s_rvalid(s_rvalid), .s_rready(s_rready),
    .on_chip_debugger_active(dbg), .option_byte_in(option_byte),
    .flash_ctrl_r(flash_ctrl_r));

  flash_array_model i_flash (.ref_clk(ref_clk), .ctrl(flash_ctrl_r),
    .opt_load(opt_load), .opt_data(opt_data), .peek_addr(peek_addr),
    .peek_byte(peek_byte), .option_byte(option_byte),
    .last_len(last_len), .last_kind(last_kind), .pulses(pulses));

  initial forever #12.5 ref_clk = ~ref_clk;

  //--------------------------------------------------------------------
  // Checking and closing
  //--------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Whole run needs a few thousand cycles; a hang ends here
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      summarize();
    end
  end

  function automatic int cyc(input int k, input int us);
    int n;
    n = (k * us + 999) / 1000;
    return (n < 1) ? 1 : n;
  endfunction

  //--------------------------------------------------------------------
  // Bus master
  //--------------------------------------------------------------------
  // Extra edge at the end so the next call never re-drives in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= 4'hF;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge ref_clk);
      if (!aw_ok && s_awready) begin
        aw_ok = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (!w_ok && s_wready) begin
        w_ok = 1'b1;
        s_wvalid <= 1'b0;
      end
    end
    while (!s_bvalid) @(posedge ref_clk);
    last_resp = s_bresp;
    s_bready <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(posedge ref_clk); while (!s_arready);
    s_arvalid <= 1'b0;
    while (!s_rvalid) @(posedge ref_clk);
    rdata_q = s_rdata;
    last_resp = s_rresp;
    s_rready <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rdata_q, exp);
  endtask

  //--------------------------------------------------------------------
  // Flash operations
  //--------------------------------------------------------------------
  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic load_opt(input logic [7:0] v);
    opt_data <= v;
    opt_load <= 1'b1;
    @(posedge ref_clk);
    opt_load <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic set_freq(input logic [15:0] k);
    khz = int'(k);
    wr(FREQH_OFS, {24'h0, k[15:8]});
    wr(FREQL_OFS, {24'h0, k[7:0]});
  endtask

  task automatic unlock(input bit via_dbg, input logic [2:0] p);
    wr(LOCK_OFS, {24'h0, KEY_FIRST});
    wr(LOCK_OFS, {24'h0, KEY_SECOND});
    if (via_dbg) begin
      rdchk(LOCK_OFS, 32'(LK_OPEN));
    end else begin
      wr(PAGE_OFS, {29'h0, p});
      rdchk(LOCK_OFS, 32'(LK_PAGE1));
      wr(PAGE_OFS, {29'h0, p});
      rdchk(LOCK_OFS, 32'(LK_OPEN));
    end
  endtask

  // A refused command must raise the refused flag and leave the array idle
  task automatic go(input logic [1:0] cmd, input bit ok, input int n);
    logic [7:0] p0;
    p0 = pulses;
    wr(CMD_OFS, {30'h0, cmd});
    if (ok) begin
      while (pulses === p0) @(posedge ref_clk);
      chk({12'h0, last_len}, 32'(n));
      chk({30'h0, last_kind}, {30'h0, cmd});
    end else begin
      rd(STAT_OFS);
      chk(rdata_q & 32'h6, 32'h1 << ST_REFUSED);
      chk({24'h0, pulses}, {24'h0, p0});
      wr(STAT_OFS, 32'h1 << ST_REFUSED);
    end
  endtask

  task automatic prog(input logic [11:0] a, input logic [7:0] d, input bit ok);
    peek_addr <= a;
    wr(ADDR_OFS, {20'h0, a});
    wr(DATA_OFS, {24'h0, d});
    go(CMD_PROG, ok, cyc(khz, int'(PROG_TIME_US)));
    if (ok)
      chk({24'h0, peek_byte}, {24'h0, d});
  endtask

  //--------------------------------------------------------------------
  // Main sequence
  //--------------------------------------------------------------------
  initial begin
    void'($urandom(5));
    do_reset();
    load_opt(8'hFF);
    rdchk(OPT_OFS, 32'hFF);
    rdchk(LOCK_OFS, 32'(LK_LOCKED));
    rdchk(SECT_OFS, {24'h0, SECT_RST});
    rd(8'h30);
    chk({30'h0, last_resp}, {30'h0, RESP_SLVERR});
    wr(8'h30, 32'h0);
    chk({30'h0, last_resp}, {30'h0, RESP_SLVERR});
    set_freq(16'h0100);
    chk({30'h0, last_resp}, {30'h0, RESP_OKAY});
    go(CMD_PROG, 1'b0, 0);
    pg = 3'($urandom_range(7));
    unlock(1'b0, pg);
    rdchk(STAT_OFS, 32'h1 << ST_UNLOCKED);
    for (int i = 0; i < 4; i++) begin
      if (i > 0)
        set_freq(16'($urandom_range(255, 20)));
      prog({pg, 9'(i)}, 8'($urandom), 1'b1);
    end
    prog({pg + 3'h1, 9'h0}, 8'h00, 1'b0);
    // Lowest supported rate keeps the erase pulses short
    set_freq(16'h0014);
    go(CMD_PAGE, 1'b1, cyc(khz, int'(PAGE_TIME_US)));
    go(CMD_MASS, 1'b0, 0);
    wr(SECT_OFS, 32'h1 << pg);
    prog({pg, 9'h1FF}, 8'h5A, 1'b0);
    // Write protect set; option byte must survive the reset
    load_opt(8'hFE);
    do_reset();
    rdchk(OPT_OFS, 32'hFE);
    set_freq(16'h0014);
    unlock(1'b0, pg);
    prog({pg, 9'h10}, 8'h11, 1'b0);
    go(CMD_PAGE, 1'b0, 0);
    go(CMD_MASS, 1'b0, 0);
    // Debugger path with write protect still set
    dbg <= 1'b1;
    wr(LOCK_OFS, 32'h0);
    rdchk(LOCK_OFS, 32'(LK_LOCKED));
    unlock(1'b1, pg);
    wr(SECT_OFS, 32'hFF);
    rdchk(SECT_OFS, 32'hFF);
    wr(SECT_OFS, 32'h00);
    rdchk(SECT_OFS, 32'h00);
    wr(SECT_OFS, 32'hFF);
    wr(PAGE_OFS, {29'h0, pg ^ 3'h4});
    rdchk(PAGE_OFS, {29'h0, pg ^ 3'h4});
    prog({pg, 9'h20}, 8'($urandom), 1'b1);
    go(CMD_PAGE, 1'b1, cyc(khz, int'(PAGE_TIME_US)));
    go(CMD_MASS, 1'b1, cyc(khz, int'(MASS_TIME_US)));
    chk({24'h0, peek_byte}, 32'hFF);
    summarize();
  end
endmodule
